// ==== rtl/irq_router_regs.svh ====
// constants of the vectored interrupt router
//
// Behaviour
// [R1] 16 system exceptions plus 32 peripheral lines
// [R2] vector 0x00 stack pointer, 0x04 reset, highest
// [R3] disabled or masked fault escalates to hard fault
// [R4] memory management fault vectors through 0x10
// [R5] bus error fault vectors through 0x14
// [R6] usage fault vectors through 0x18
// [R7] call, monitor, deferred, tick at 0x2C..0x3C
// [R8] line n is exception 16+n, offset 4*num
// [R9] software sets bit zero of every vector
// [R10] nmi from any pin, or disconnected
// [R11] collect requests, present vector to core
// [R12] three to eight priority bits, changeable live
// [R13] priority splits into preempt and sub-priority
// [R14] tail-chain and late arrival during entry
// [R15] state saved on entry, restored on exit
// [R16] equal priority: lower vector number first
// [R17] each line selects fixed, dma or logic source
// [R18] dma source from hub term-out group 0/1
// [R19] logic source is logic-array bit n
// [R20] logic array routes any source anywhere
// [R21] fixed sources per line, others reserved
// [R22] pending holds until taken or cleared
`ifndef IRQ_ROUTER_REGS_SVH
`define IRQ_ROUTER_REGS_SVH

`define NUM_EXC 48
`define NUM_IRQ 32
`define EXC_IRQ_BASE 6'h10
`define EXC_NMI 6'h02
`define EXC_HARD 6'h03
`define EXC_MEM 6'h04
`define EXC_SVC 6'h0b
`define EXC_DEBUG 6'h0c
`define EXC_DEFER 6'h0e
`define EXC_TICK 6'h0f
`define EXC_RESET 6'h01
`define VEC_OFF_SP 10'h000
`define VEC_OFF_RESET 10'h004
`define PRIO_NMI 9'h001
`define PRIO_HARD 9'h002
`define PRIO_PROG_BASE 9'h003
`define PRIO_IDLE 9'h1ff
`define FIXED_PRESENT 32'he3e0fffb
`define NMI_PIN_COUNT 8
`define NMI_SEL_W 3
`define CNT_W 8

`endif

// ==== rtl/irq_router_pkg.sv ====
// types of the vectored interrupt router
`include "irq_router_regs.svh"
package irq_router_pkg;

	typedef enum logic [5:0] {
		ST_BOOT_SP = 6'h01,
		ST_BOOT_RST = 6'h02,
		ST_RUN = 6'h04,
		ST_STACK = 6'h08,
		ST_VECTOR = 6'h10,
		ST_UNSTACK = 6'h20
	} state_t;

	typedef enum logic [1:0] {
		SRC_FIXED = 2'h0,
		SRC_DMA = 2'h1,
		SRC_LOGIC = 2'h2,
		SRC_NONE = 2'h3
	} src_sel_t;

	typedef struct packed {
		logic take;
		logic [5:0] exc_num;
		logic [9:0] vec_off;
		logic saving;
		logic restoring;
		logic tail_chain;
	} core_req_t;

	typedef struct packed {
		logic mem_fault;
		logic bus_fault;
		logic usage_fault;
		logic supervisor_call;
		logic debug_monitor;
		logic deferred_service_request;
		logic system_tick_timer;
	} sys_evt_t;

	typedef struct packed {
		state_t state;
		logic [`CNT_W-1:0] cnt;
		logic [`NUM_EXC-1:0] pend;
		logic [`NUM_EXC-1:0] active;
		logic [5:0] cur_num;
		core_req_t req;
		logic [`NMI_PIN_COUNT-1:0] nmi_s1;
		logic [`NMI_PIN_COUNT-1:0] nmi_s2;
		logic nmi_q;
	} st_t;

endpackage

// ==== rtl/vectored_interrupt_router.sv ====
// vectored interrupt router: source select, arbitration, entry and exit sequencing
`timescale 1ns/1ps
`include "irq_router_regs.svh"
module vectored_interrupt_router #(
	parameter int PRIO_BITS = 3,
	parameter int SAVE_CYCLES = 8,
	parameter int RESTORE_CYCLES = 8
) (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic [`NUM_IRQ-1:0] FIXED_IRQ,
	input wire logic [15:0] HUB_DMA_TERM_OUT_GROUP0,
	input wire logic [15:0] HUB_DMA_TERM_OUT_GROUP1,
	input wire logic [`NUM_IRQ-1:0] LOGIC_IRQ,
	input wire irq_router_pkg::src_sel_t [`NUM_IRQ-1:0] SRC_SEL,
	input wire logic [`NUM_IRQ-1:0] IRQ_ENABLE,
	input wire logic [`NUM_IRQ-1:0][PRIO_BITS-1:0] IRQ_PRIO,
	input wire logic [6:0][PRIO_BITS-1:0] SYS_PRIO,
	input wire logic [2:0] PRIO_GROUP,
	input wire logic MASK_PROG,
	input wire logic [2:0] FAULT_ENABLE,
	input wire irq_router_pkg::sys_evt_t SYS_EVT,
	input wire logic [`NUM_EXC-1:0] PEND_CLEAR,
	input wire logic [`NMI_PIN_COUNT-1:0] NMI_PINS,
	input wire logic NMI_ROUTE_EN,
	input wire logic [`NMI_SEL_W-1:0] NMI_ROUTE_SEL,
	input wire logic TAKE_ACK,
	input wire logic HANDLER_DONE,
	output irq_router_pkg::core_req_t CORE_REQ,
	output logic [`NUM_EXC-1:0] PEND_STATUS,
	output logic [`NUM_EXC-1:0] ACTIVE_STATUS
);
	import irq_router_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (PRIO_BITS < 3 || PRIO_BITS > 8) begin : g_prio_chk
		$error("PRIO_BITS must lie between 3 and 8");
	end
	// the save and restore counter is CNT_W bits wide
	if (SAVE_CYCLES < 1 || SAVE_CYCLES > 256) begin : g_save_chk
		$error("SAVE_CYCLES must lie between 1 and 256");
	end
	if (RESTORE_CYCLES < 1 || RESTORE_CYCLES > 256) begin : g_restore_chk
		$error("RESTORE_CYCLES must lie between 1 and 256");
	end
	// every value of the pin select must name a real pin
	if (`NMI_PIN_COUNT != (1 << `NMI_SEL_W)) begin : g_pin_chk
		$error("pin count must equal two to the select width");
	end

	////////////////////////////////////////////////////////////////////////////////
	// functions

	// preempting part: sub-priority bits below the group split are dropped
	function automatic logic [8:0] grp_of(input logic [7:0] p, input logic [2:0] g);
		logic [7:0] m;
		m = 8'hff << g;
		return {1'b0, p & m} + `PRIO_PROG_BASE; // [R13]
	endfunction

	function automatic logic [9:0] vec_off(input logic [5:0] num);
		return {2'h0, num, 2'h0}; // [R8]
	endfunction

	// system exceptions that carry a programmable priority, in input order
	function automatic logic [5:0] sys_num(input logic [2:0] k);
		case (k)
			3'h0: return `EXC_MEM; // [R4]
			3'h1: return 6'h05; // [R5]
			3'h2: return 6'h06; // [R6]
			3'h3: return `EXC_SVC; // [R7]
			3'h4: return `EXC_DEBUG; // [R7]
			3'h5: return `EXC_DEFER; // [R7]
			default: return `EXC_TICK; // [R7]
		endcase
	endfunction

	function automatic logic route(input src_sel_t sel, input logic fx, input logic dma,
		input logic lg);
		case (sel)
			SRC_FIXED: return fx; // [R17]
			SRC_DMA: return dma; // [R18]
			SRC_LOGIC: return lg; // [R19] [R20]
			default: return 1'b0;
		endcase
	endfunction

	// fixed-priority exceptions ignore the mask; peripheral lines need their enable too
	function automatic logic may_take(input int i, input logic mask,
		input logic [`NUM_IRQ-1:0] en);
		logic ok;
		ok = 1'b1;
		if (i >= 4 && mask) begin
			ok = 1'b0; // [R3]
		end else if (i >= 16) begin
			ok = en[5'(i - 16)];
		end
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	st_t st_ff;
	st_t nxt_st;

	logic [8:0] full_p [`NUM_EXC]; // [R1]
	logic [8:0] grp_p [`NUM_EXC];
	logic [8:0] running;
	logic [5:0] cur;
	logic [8:0] best;
	logic [5:0] win;
	logic win_valid;
	logic preempt;
	logic nmi_sel;
	logic [`NUM_IRQ-1:0] fixed_ok;
	logic [`NUM_IRQ-1:0] dma_term;

	assign fixed_ok = FIXED_IRQ & `FIXED_PRESENT; // [R21]
	assign dma_term = {HUB_DMA_TERM_OUT_GROUP1, HUB_DMA_TERM_OUT_GROUP0}; // [R18]
	// only the second sync stage feeds the pin select
	assign nmi_sel = NMI_ROUTE_EN & st_ff.nmi_s2[NMI_ROUTE_SEL]; // [R10]

	////////////////////////////////////////////////////////////////////////////////
	// priorities, read live so they may change while running

	always_comb begin
		for (int i = 0; i < `NUM_EXC; i++) begin
			full_p[i] = `PRIO_IDLE;
			grp_p[i] = `PRIO_IDLE;
		end
		full_p[`EXC_NMI] = `PRIO_NMI; // [R3]
		grp_p[`EXC_NMI] = `PRIO_NMI;
		full_p[`EXC_HARD] = `PRIO_HARD; // [R3]
		grp_p[`EXC_HARD] = `PRIO_HARD;
		for (int k = 0; k < 7; k++) begin
			full_p[sys_num(3'(k))] = grp_of(8'(SYS_PRIO[k]), 3'h0); // [R12]
			grp_p[sys_num(3'(k))] = grp_of(8'(SYS_PRIO[k]), PRIO_GROUP);
		end
		for (int n = 0; n < `NUM_IRQ; n++) begin
			full_p[16 + n] = grp_of(8'(IRQ_PRIO[n]), 3'h0); // [R12]
			grp_p[16 + n] = grp_of(8'(IRQ_PRIO[n]), PRIO_GROUP);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// arbitration

	always_comb begin
		running = `PRIO_IDLE;
		cur = 6'h00;
		// most recently entered handler holds the strongest group priority
		for (int i = 0; i < `NUM_EXC; i++) begin
			if (st_ff.active[i] && grp_p[i] < running) begin
				running = grp_p[i];
				cur = 6'(i);
			end
		end
		best = `PRIO_IDLE;
		win = 6'h00;
		win_valid = 1'b0;
		// scan downward with <= so the lower number wins a tie
		for (int i = `NUM_EXC - 1; i >= 0; i--) begin
			if (st_ff.pend[i] && full_p[i] <= best &&
				may_take(i, MASK_PROG, IRQ_ENABLE)) begin // [R16]
				best = full_p[i];
				win = 6'(i);
				win_valid = 1'b1;
			end
		end
		preempt = win_valid && grp_p[win] < running; // [R13]
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [`NUM_EXC-1:0] set;
		logic [`NUM_EXC-1:0] take_clr;
		set = '0;
		take_clr = '0;
		nxt_st = st_ff;
		nxt_st.nmi_s1 = NMI_PINS;
		nxt_st.nmi_s2 = st_ff.nmi_s1;
		nxt_st.nmi_q = nmi_sel;

		for (int n = 0; n < `NUM_IRQ; n++) begin
			set[16 + n] = route(SRC_SEL[n], fixed_ok[n], dma_term[n], LOGIC_IRQ[n]); // [R11]
		end
		set[`EXC_NMI] = nmi_sel & ~st_ff.nmi_q; // [R10]
		for (int k = 0; k < 3; k++) begin
			if (SYS_EVT[6 - k]) begin
				if (!FAULT_ENABLE[k] || !may_take(4 + k, MASK_PROG, IRQ_ENABLE) ||
					grp_p[4 + k] >= running) begin
					set[`EXC_HARD] = 1'b1; // [R3]
				end else begin
					set[4 + k] = 1'b1; // [R4] [R5] [R6]
				end
			end
		end
		set[`EXC_SVC] = SYS_EVT.supervisor_call; // [R7]
		set[`EXC_DEBUG] = SYS_EVT.debug_monitor;
		set[`EXC_DEFER] = SYS_EVT.deferred_service_request;
		set[`EXC_TICK] = SYS_EVT.system_tick_timer;

		case (st_ff.state)
			ST_BOOT_SP: begin
				if (TAKE_ACK) begin
					nxt_st.state = ST_BOOT_RST;
					nxt_st.req.exc_num = `EXC_RESET; // [R2]
					nxt_st.req.vec_off = `VEC_OFF_RESET;
				end
			end
			ST_BOOT_RST: begin
				if (TAKE_ACK) begin
					nxt_st.state = ST_RUN;
					nxt_st.req.take = 1'b0;
				end
			end
			ST_RUN: begin
				if (HANDLER_DONE && st_ff.active != '0) begin
					nxt_st.active[cur] = 1'b0;
					nxt_st.state = ST_UNSTACK;
					nxt_st.req.restoring = 1'b1; // [R15]
					nxt_st.cnt = '0;
				end else if (preempt) begin
					nxt_st.state = ST_STACK;
					nxt_st.req.saving = 1'b1; // [R15]
					nxt_st.cnt = '0;
				end
			end
			ST_STACK: begin
				// winner is chosen only at the end, so a late arrival still gets in
				if (st_ff.cnt == `CNT_W'(SAVE_CYCLES - 1)) begin
					nxt_st.req.saving = 1'b0;
					nxt_st.cnt = '0;
					if (preempt) begin
						nxt_st.state = ST_VECTOR; // [R14]
						nxt_st.cur_num = win;
						nxt_st.req.take = 1'b1;
						nxt_st.req.exc_num = win;
						nxt_st.req.vec_off = vec_off(win); // [R8]
					end else begin
						nxt_st.state = ST_UNSTACK;
						nxt_st.req.restoring = 1'b1;
					end
				end else begin
					nxt_st.cnt = st_ff.cnt + `CNT_W'(1);
				end
			end
			ST_VECTOR: begin
				if (TAKE_ACK) begin
					nxt_st.active[st_ff.cur_num] = 1'b1;
					take_clr[st_ff.cur_num] = 1'b1; // [R22]
					nxt_st.req.take = 1'b0;
					nxt_st.req.tail_chain = 1'b0;
					nxt_st.state = ST_RUN;
				end
			end
			ST_UNSTACK: begin
				// a preempting request skips the restore and the next save
				if (preempt) begin
					nxt_st.state = ST_VECTOR; // [R14]
					nxt_st.req.restoring = 1'b0;
					nxt_st.req.tail_chain = 1'b1;
					nxt_st.cur_num = win;
					nxt_st.req.take = 1'b1;
					nxt_st.req.exc_num = win;
					nxt_st.req.vec_off = vec_off(win);
				end else if (st_ff.cnt == `CNT_W'(RESTORE_CYCLES - 1)) begin
					nxt_st.state = ST_RUN;
					nxt_st.req.restoring = 1'b0; // [R15]
				end else begin
					nxt_st.cnt = st_ff.cnt + `CNT_W'(1);
				end
			end
			default: begin
				nxt_st.state = ST_RUN;
				nxt_st.req = '0;
			end
		endcase

		// a new request in the clearing cycle wins
		nxt_st.pend = (st_ff.pend & ~PEND_CLEAR & ~take_clr) | set; // [R22]
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			st_ff <= '0;
			st_ff.state <= ST_BOOT_SP;
			st_ff.req.take <= 1'b1; // [R2]
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, taken straight from the state register

	assign CORE_REQ = st_ff.req;
	assign PEND_STATUS = st_ff.pend;
	assign ACTIVE_STATUS = st_ff.active;

endmodule

// ==== dv/vectored_interrupt_router_props.sv ====
// assertion checker for the vectored interrupt router
`timescale 1ns/1ps
module irq_router_props (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire irq_router_pkg::core_req_t CORE_REQ,
	input wire logic [47:0] PEND_STATUS,
	input wire logic [47:0] ACTIVE_STATUS,
	input wire logic [47:0] PEND_CLEAR,
	input wire logic TAKE_ACK,
	input wire logic HANDLER_DONE,
	input wire logic NMI_ROUTE_EN
);
	import irq_router_pkg::*;
	default clocking dc @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	////////////////////////////////////////////////////////////////
	chk_off_four: assert property (
		CORE_REQ.take |-> CORE_REQ.vec_off == {2'h0, CORE_REQ.exc_num, 2'h0})
		else $error("offset not four times number");
	chk_boot_start: assert property (
		$fell(RESET) |-> CORE_REQ.take && CORE_REQ.vec_off == 10'h000)
		else $error("no stack pointer fetch after reset");
	chk_boot_reset: assert property (
		CORE_REQ.take && CORE_REQ.exc_num == 6'h00 && TAKE_ACK
		|=> CORE_REQ.take && CORE_REQ.exc_num == 6'h01)
		else $error("reset vector not offered second");
	chk_ack_drop: assert property (
		CORE_REQ.take && TAKE_ACK && CORE_REQ.exc_num != 6'h00 |=> !CORE_REQ.take)
		else $error("offer held after ack");
	chk_take_active: assert property (
		CORE_REQ.take && TAKE_ACK && CORE_REQ.exc_num > 6'h01
		|=> ACTIVE_STATUS[$past(CORE_REQ.exc_num)])
		else $error("taken exception not active");
	chk_pend_hold: assert property (
		PEND_STATUS[16] && !PEND_CLEAR[16]
		&& !(CORE_REQ.take && TAKE_ACK && CORE_REQ.exc_num == 6'h10) |=> PEND_STATUS[16])
		else $error("pending dropped early");
	chk_done_restore: assert property (
		HANDLER_DONE && |ACTIVE_STATUS && !CORE_REQ.take && !CORE_REQ.saving
		&& !CORE_REQ.restoring |=> CORE_REQ.restoring)
		else $error("no restore after return");
	chk_save_bound: assert property (
		$rose(CORE_REQ.saving) |-> ##[1:20] (CORE_REQ.take || CORE_REQ.restoring))
		else $error("save never ends");
	chk_tail_take: assert property (
		CORE_REQ.tail_chain |-> CORE_REQ.take)
		else $error("tail chain without offer");
	chk_nmi_off: assert property (
		!NMI_ROUTE_EN [*5] ##0 !PEND_STATUS[2] |=> !PEND_STATUS[2])
		else $error("nmi pended while disconnected");
	cover property (CORE_REQ.tail_chain);
	cover property ($rose(CORE_REQ.restoring));
	cover property (CORE_REQ.take && CORE_REQ.exc_num == 6'h03);
endmodule
////////////////////////////////////////////////////////////////
bind vectored_interrupt_router irq_router_props chk (
	.REF_CLK(REF_CLK), .RESET(RESET), .CORE_REQ(CORE_REQ), .PEND_STATUS(PEND_STATUS),
	.ACTIVE_STATUS(ACTIVE_STATUS), .PEND_CLEAR(PEND_CLEAR), .TAKE_ACK(TAKE_ACK),
	.HANDLER_DONE(HANDLER_DONE), .NMI_ROUTE_EN(NMI_ROUTE_EN));

// ==== dv/core_model.sv ====
// behavioural processor core: acks vector offers, returns on request
`timescale 1ns/1ps
module core_model (
	input wire logic clk,
	input wire logic rst,
	input wire irq_router_pkg::core_req_t req,
	input wire logic [3:0] ack_dly,
	input wire logic done_req,
	output logic ack_ff,
	output logic done_ff,
	output logic [31:0] entry_ff
);
	import irq_router_pkg::*;
	logic [3:0] wait_ff;
	always_ff @(posedge clk) begin
		ack_ff <= 1'b0;
		done_ff <= done_req; // returns only when the bench asks
		if (rst) begin
			wait_ff <= 4'h0;
		end else if (req.take && !ack_ff) begin
			if (wait_ff >= ack_dly) begin
				ack_ff <= 1'b1;
				wait_ff <= 4'h0;
				entry_ff <= {22'h0, req.vec_off} | 32'h1;
			end else begin
				wait_ff <= wait_ff + 4'h1;
			end
		end
	end
endmodule

// ==== dv/tb_vectored_interrupt_router.sv ====
// self-checking bench for the vectored interrupt router
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("Error %0t got %h exp %h", $time, (a), (b)); end end
module tb_vectored_interrupt_router;
	import irq_router_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic done_req = 1'b0;
	logic ack, done;
	logic [3:0] dly = 4'h0;
	logic [31:0] fix = '0;
	logic [31:0] lgc = '0;
	logic [31:0] en = '1;
	logic [15:0] dma0 = '0;
	logic [15:0] dma1 = '0;
	src_sel_t [31:0] sel;
	logic [31:0][2:0] prio = '0;
	logic [2:0] fen = 3'h7;
	sys_evt_t evt = '0;
	logic [7:0] pins = '0;
	logic nen = 1'b0;
	logic [2:0] grp = 3'h0;
	logic mask = 1'b0;
	logic [47:0] pclr = '0;
	logic [31:0] entry;
	core_req_t req;
	logic [47:0] pend, act;
	int err_count = 0;
	int tests_run = 0;
	////////////////////////////////////////////////////////////////
	vectored_interrupt_router #(.SAVE_CYCLES(2), .RESTORE_CYCLES(2)) uut (
		.REF_CLK(clk), .RESET(rst), .FIXED_IRQ(fix), .HUB_DMA_TERM_OUT_GROUP0(dma0),
		.HUB_DMA_TERM_OUT_GROUP1(dma1), .LOGIC_IRQ(lgc), .SRC_SEL(sel), .IRQ_ENABLE(en),
		.IRQ_PRIO(prio), .SYS_PRIO('0), .PRIO_GROUP(grp), .MASK_PROG(mask),
		.FAULT_ENABLE(fen), .SYS_EVT(evt), .PEND_CLEAR(pclr), .NMI_PINS(pins),
		.NMI_ROUTE_EN(nen), .NMI_ROUTE_SEL(3'h5), .TAKE_ACK(ack), .HANDLER_DONE(done),
		.CORE_REQ(req), .PEND_STATUS(pend), .ACTIVE_STATUS(act));
	core_model core (.clk(clk), .rst(rst), .req(req), .ack_dly(dly),
		.done_req(done_req), .ack_ff(ack), .done_ff(done), .entry_ff(entry));
	initial begin
		forever #10 clk = ~clk;
	end
	initial foreach (sel[i]) sel[i] = SRC_LOGIC;
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic serve(input logic [5:0] e, input logic tc);
		int k;
		for (k = 0; k < 100 && req.take !== 1'b1; k++) tick(1);
		`CHK(req.exc_num, e)
		`CHK(req.vec_off, {2'h0, e, 2'h0})
		`CHK(req.tail_chain, tc)
		for (k = 0; k < 100 && req.take === 1'b1; k++) tick(1);
		`CHK(act[e], 1'b1)
		`CHK(pend[e], 1'b0)
		`CHK(entry, {24'h0, e, 2'h1})
		leave(e);
	endtask
	task automatic leave(input logic [5:0] e);
		int k;
		done_req = 1'b1;
		tick(1);
		done_req = 1'b0;
		tick(2);
		for (k = 0; k < 100 && req.restoring === 1'b1; k++) tick(1);
		`CHK(act[e], 1'b0)
	endtask
	task automatic t_boot;
		int k;
		`CHK(req.take, 1'b1)
		`CHK(req.vec_off, 10'h000)
		for (k = 0; k < 20 && req.exc_num !== 6'h01; k++) tick(1);
		`CHK(req.vec_off, 10'h004)
		tick(3);
		`CHK(req.take, 1'b0)
	endtask
	// d is the class that pulses; only a match may pend, and a fixed match only on a present line
	task automatic fire(input int n, input src_sel_t s, input src_sel_t d, input logic hit);
		sel[n] = s;
		fix[n] = (d == SRC_FIXED);
		lgc[n] = (d == SRC_LOGIC);
		if (n < 16) dma0[n] = (d == SRC_DMA);
		else dma1[n - 16] = (d == SRC_DMA);
		tick(1);
		fix = '0;
		lgc = '0;
		dma0 = '0;
		dma1 = '0;
		`CHK(pend[16 + n], hit)
		if (hit) serve(6'(16 + n), 1'b0);
	endtask
	task automatic t_sources;
		dly = 4'h3;
		fire(0, SRC_FIXED, SRC_FIXED, 1'b1);
		fire(2, SRC_FIXED, SRC_FIXED, 1'b0);
		fire(31, SRC_FIXED, SRC_FIXED, 1'b1);
		fire(9, SRC_DMA, SRC_DMA, 1'b1);
		fire(20, SRC_DMA, SRC_DMA, 1'b1);
		fire(20, SRC_DMA, SRC_LOGIC, 1'b0);
		fire(13, SRC_LOGIC, SRC_LOGIC, 1'b1);
		fire(13, SRC_NONE, SRC_FIXED, 1'b0);
		fire(26, SRC_LOGIC, SRC_LOGIC, 1'b1);
		dly = 4'h0;
	endtask
	task automatic t_order(input logic [2:0] p3, input logic [2:0] p7, input logic [5:0] e);
		en[3] = 1'b0;
		en[7] = 1'b0;
		prio[3] = p3;
		prio[7] = p7;
		lgc = 32'h88;
		tick(1);
		lgc = '0;
		tick(3);
		`CHK(pend[23:19], 5'h11)
		`CHK(act[23:19], 5'h00)
		en = '1;
		serve(e, 1'b0);
		serve(e == 6'h13 ? 6'h17 : 6'h13, 1'b1);
	endtask
	task automatic t_nmi;
		pins = 8'h20;
		tick(6);
		`CHK(pend[2], 1'b0)
		pins = 8'h00;
		tick(4);
		nen = 1'b1;
		tick(4);
		pins = 8'h20;
		serve(6'h02, 1'b0);
		pins = 8'h00;
		tick(4);
		nen = 1'b0;
	endtask
	task automatic t_faults;
		logic [5:0] exc [7] = '{6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0e, 6'h0f};
		for (int i = 0; i < 7; i++) begin
			evt = sys_evt_t'(7'h40 >> i);
			tick(1);
			evt = '0;
			serve(exc[i], 1'b0);
		end
		fen = 3'h6;
		evt = sys_evt_t'(7'h40);
		tick(1);
		evt = '0;
		serve(6'h03, 1'b0);
		fen = 3'h7;
	endtask
	// a set in the clearing cycle wins; a clear alone drops the pending bit
	task automatic t_clear;
		en[5] = 1'b0;
		lgc = 32'h20;
		tick(1);
		pclr[21] = 1'b1;
		tick(1);
		lgc = 32'h00;
		`CHK(pend[21], 1'b1)
		tick(1);
		pclr = '0;
		`CHK(pend[21], 1'b0)
		en = '1;
		tick(4);
		`CHK(act[21] | req.take, 1'b0)
	endtask
	task automatic t_mask;
		mask = 1'b1;
		lgc = 32'h02;
		evt = sys_evt_t'(7'h40);
		tick(1);
		lgc = 32'h00;
		evt = '0;
		`CHK(pend[17], 1'b1)
		`CHK(pend[4], 1'b0)
		serve(6'h03, 1'b0);
		`CHK(act[17] | req.take, 1'b0)
		mask = 1'b0;
		serve(6'h11, 1'b0);
	endtask
	// line 7 outranks line 3 only while the low priority bit is not sub-priority
	task automatic t_group(input logic [2:0] g);
		int k;
		grp = g;
		prio[3] = 3'h3;
		prio[7] = 3'h2;
		lgc = 32'h08;
		tick(1);
		lgc = 32'h00;
		for (k = 0; k < 40 && act[19] !== 1'b1; k++) tick(1);
		lgc = 32'h80;
		tick(1);
		lgc = 32'h00;
		tick(6);
		`CHK(act[23], g == 3'h0)
		if (g == 3'h0) begin
			leave(6'h17);
			leave(6'h13);
		end else begin
			leave(6'h13);
			serve(6'h17, 1'b1);
		end
		grp = 3'h0;
	endtask
	task automatic complete_run;
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_boot;
		t_sources;
		t_order(3'h2, 3'h2, 6'h13);
		t_order(3'h2, 3'h1, 6'h17);
		t_nmi;
		t_faults;
		t_clear;
		t_mask;
		t_group(3'h0);
		t_group(3'h1);
		rst = 1'b1;
		tick(3);
		`CHK({pend, act}, 96'h0)
		rst = 1'b0;
		t_boot;
		complete_run;
	end
	// run needs a few hundred cycles; twenty thousand means a hang
	initial begin
		#400000;
		err_count++;
		complete_run;
	end
endmodule
